/* logic/adc_clk_consts.vh */
// constants for the converter clock and pair-ready status block
// assumes an apb slave at 40 MHz with 32-bit data, one word per register
//
// Contract
// - select codes divide source clock by 4 to 18
// - pll on: codes 001/000 act as 010
// - six ready flags at bits 5..0, rest unimplemented
// - hardware sets flag on buffer write, software clears
`ifndef ADC_CLK_CONSTS_VH
`define ADC_CLK_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL   12'h000
`define OFS_STATUS    12'h004
`define OFS_IRQ_STAT  12'h008
`define OFS_IRQ_MASK  12'h00c

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SEL_LSB       0
`define SEL_MSB       2
`define PLL_BIT       3
`define NUM_PAIRS     6
`define CONTROL_RST   16'h0000
`define SEL_FALLBACK  3'h2

`endif

/* logic/conv_clk_divider.v */
// programmable divider for the converter clock
// assumes the source clock arrives as a one-cycle enable on i_clk
`timescale 1ns/1ps

module conv_clk_divider (
  input  wire       i_clk,    // system clock
  input  wire       i_rstn,   // async reset, active low
  input  wire       i_src_en, // converter source clock enable
  input  wire [4:0] i_ratio,  // divide ratio, even, 4..18
  output reg        o_tick    // one-cycle converter clock enable
);

  reg [4:0] cnt_q;

  // the count restarts on every wrap, so a ratio change lands within one period
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q  <= 5'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_src_en) begin
        if (cnt_q >= i_ratio - 5'h01) begin
          cnt_q  <= 5'h00;
          o_tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

endmodule // conv_clk_divider

/* logic/adc_clock_and_ready_status.v */
// converter clock select and pair-ready status, apb register slave
// assumes i_buf_wr pulses are synchronous to i_clk
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "adc_clk_consts.vh"

module adc_clock_and_ready_status (
  input  wire        i_clk,       // 40 MHz system clock
  input  wire        i_rstn,      // async reset, active low
  input  wire        i_src_en,    // converter source clock enable pulse
  input  wire [5:0]  i_buf_wr,    // pulse: pair n result written to buffer
  input  wire        i_psel,      // apb select
  input  wire        i_penable,   // apb enable
  input  wire        i_pwrite,    // apb write
  input  wire [11:0] i_paddr,     // apb byte address
  input  wire [31:0] i_pwdata,    // apb write data
  output reg  [31:0] o_prdata,    // apb read data
  output reg         o_pready,    // apb ready
  output reg         o_pslverr,   // apb error, unmapped address
  output reg         o_conv_tick, // converter clock enable pulse
  output reg  [2:0]  o_eff_sel,   // select in effect after fallback
  output reg  [5:0]  o_pair_ready,// ready flags
  output reg         o_irq        // level interrupt
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  reg  [15:0] control_q;
  reg  [5:0]  status_q;
  reg  [5:0]  irq_stat_q;
  reg  [5:0]  irq_mask_q;
  wire        setup  = i_psel & ~i_penable;
  wire        access = i_psel & i_penable & o_pready;
  wire        wr     = access & i_pwrite;
  wire        rd     = access & ~i_pwrite;
  wire        hit    = (i_paddr == `OFS_CONTROL) | (i_paddr == `OFS_STATUS) |
                       (i_paddr == `OFS_IRQ_STAT) | (i_paddr == `OFS_IRQ_MASK);

  // no wait states: pready rises in the first access cycle
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~hit;
      o_prdata  <= 32'h0000_0000;
      if (setup && !i_pwrite) begin
        case (i_paddr)
          `OFS_CONTROL:  o_prdata <= {16'h0000, control_q};
          `OFS_STATUS:   o_prdata <= {26'h0000000, status_q};
          `OFS_IRQ_STAT: o_prdata <= {26'h0000000, irq_stat_q};
          `OFS_IRQ_MASK: o_prdata <= {26'h0000000, irq_mask_q};
          default:       o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control register and clock select
  // ----------------------------------------------------------------
  wire [2:0] sel_raw = control_q[`SEL_MSB:`SEL_LSB];
  wire       pll_on  = control_q[`PLL_BIT];
  reg  [2:0] sel_d;
  reg  [4:0] ratio;

  always @* begin
    sel_d = sel_raw;
    if (pll_on && (sel_raw == 3'h1 || sel_raw == 3'h0))
      sel_d = `SEL_FALLBACK;
    ratio = {1'b0, sel_d, 1'b0} + 5'h04;
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      control_q <= `CONTROL_RST;
      o_eff_sel <= 3'h0;
    end else begin
      if (wr && i_paddr == `OFS_CONTROL)
        control_q <= {12'h000, i_pwdata[3:0]};
      o_eff_sel <= sel_d;
    end
  end

  wire tick;
  conv_clk_divider u_div (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_src_en (i_src_en),
    .i_ratio  (ratio),
    .o_tick   (tick)
  );

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      o_conv_tick <= 1'b0;
    else
      o_conv_tick <= tick;
  end

  // ----------------------------------------------------------------
  // ready flags and interrupt
  // ----------------------------------------------------------------
  wire st_wr  = wr & (i_paddr == `OFS_STATUS);
  wire is_rd  = rd & (i_paddr == `OFS_IRQ_STAT);
  wire mk_wr  = wr & (i_paddr == `OFS_IRQ_MASK);

  genvar g;
  generate
    for (g = 0; g < `NUM_PAIRS; g = g + 1) begin : g_pair
      // a set in the clearing cycle wins, so no buffer event is lost
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          status_q[g]   <= 1'b0;
          irq_stat_q[g] <= 1'b0;
        end else begin
          if (i_buf_wr[g])
            status_q[g] <= 1'b1;
          else if (st_wr && !i_pwdata[g])
            status_q[g] <= 1'b0;
          if (i_buf_wr[g])
            irq_stat_q[g] <= 1'b1;
          else if (is_rd)
            irq_stat_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mask_q   <= 6'h00;
      o_pair_ready <= 6'h00;
      o_irq        <= 1'b0;
    end else begin
      if (mk_wr)
        irq_mask_q <= i_pwdata[5:0];
      o_pair_ready <= status_q;
      o_irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // adc_clock_and_ready_status

/* verif/adc_status_chk.sv */
// checker for converter clock and pair-ready status
// assumes one clock domain, apb byte addresses
`timescale 1ns/1ps
module adc_status_chk (
  input wire        i_clk, i_rstn, i_psel, i_penable, i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata, o_prdata,
  input wire        o_pready, o_conv_tick,
  input wire [2:0]  o_eff_sel,
  input wire [5:0]  i_buf_wr, o_pair_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire wr_st = i_psel && i_penable && i_pwrite && i_paddr == 12'h004;
  reg  pll_q;
  // shadow of the pll bit, taken at the access edge
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn) pll_q <= 1'b0;
    else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h000) pll_q <= i_pwdata[3];
  a_upper_zero: assert property (
    o_pready && !i_pwrite && i_paddr == 12'h004 |-> o_prdata[31:6] == 26'h0)
    else $error("status upper bits set");
  a_flag_set: assert property (i_buf_wr[5] |=> ##1 o_pair_ready[5])
    else $error("flag not set");
  a_clear_zero: assert property (
    $fell(o_pair_ready[0]) |-> $past(wr_st, 2) && !$past(i_pwdata[0], 2))
    else $error("flag fell without zero write");
  a_tick_gap: assert property (o_conv_tick |=> !o_conv_tick [*3])
    else $error("ticks too close");
  a_pll_fallback: assert property (pll_q [*4] |-> o_eff_sel[2:1] != 2'b00)
    else $error("reserved select in effect");
  cover property (wr_st && !i_pwdata[0]);
  cover property (pll_q && o_conv_tick);
  cover property (i_buf_wr == 6'h3f);
endmodule // adc_status_chk
bind adc_clock_and_ready_status adc_status_chk u_chk (
  .i_clk        (i_clk),
  .i_rstn       (i_rstn),
  .i_psel       (i_psel),
  .i_penable    (i_penable),
  .i_pwrite     (i_pwrite),
  .i_paddr      (i_paddr),
  .i_pwdata     (i_pwdata),
  .o_prdata     (o_prdata),
  .o_pready     (o_pready),
  .o_conv_tick  (o_conv_tick),
  .o_eff_sel    (o_eff_sel),
  .i_buf_wr     (i_buf_wr),
  .o_pair_ready (o_pair_ready)
);

/* verif/tb.sv */
// bench for converter clock and pair-ready status
// assumes apb answers within a few cycles
`timescale 1ns/1ps
`define CHK(n,e,s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  logic        i_clk = 0, i_rstn = 0, i_src_en = 0;
  logic        i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [5:0]  i_buf_wr = 6'h00, o_pair_ready;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic        o_pready, o_pslverr, o_conv_tick, o_irq, err;
  logic [2:0]  o_eff_sel;
  int          err_count = 0, total_checks = 0;
  always #12.5 i_clk = ~i_clk;
  adc_clock_and_ready_status u_adc_clock_and_ready_status (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_src_en     (i_src_en),
    .i_buf_wr     (i_buf_wr),
    .i_psel       (i_psel),
    .i_penable    (i_penable),
    .i_pwrite     (i_pwrite),
    .i_paddr      (i_paddr),
    .i_pwdata     (i_pwdata),
    .o_prdata     (o_prdata),
    .o_pready     (o_pready),
    .o_pslverr    (o_pslverr),
    .o_conv_tick  (o_conv_tick),
    .o_eff_sel    (o_eff_sel),
    .o_pair_ready (o_pair_ready),
    .o_irq        (o_irq)
  );
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    // values read right after an edge are those the design sampled at it
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_pready !== 1 && n < 9);
    if (o_pready !== 1) begin err_count++; give_verdict; end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task tick(output int c);
    c = 0;
    do begin @(posedge i_clk); c++; end while (o_conv_tick !== 1 && c < 60);
    if (c == 60) begin err_count++; give_verdict; end
  endtask
  task pulse(input logic [5:0] v);
    i_buf_wr <= v;
    @(posedge i_clk);
    i_buf_wr <= 6'h00;
  endtask
  task t_status;
    apb(0, 12'h004, 0);
    `CHK("flags", 32'h0, rd)
    apb(1, 12'h00c, 32'h3f);
    pulse(6'h3f);
    apb(0, 12'h004, 0);
    `CHK("flags", 32'h3f, rd)
    `CHK("pair_ready", 6'h3f, o_pair_ready)
    `CHK("irq", 1'b1, o_irq)
    apb(1, 12'h004, 32'hffff_ffd5);
    apb(0, 12'h004, 0);
    `CHK("flags", 32'h15, rd)
    apb(1, 12'h004, 0);
    apb(0, 12'h004, 0);
    `CHK("flags", 32'h0, rd)
    apb(0, 12'h008, 0);
    apb(1, 12'h00c, 32'h3e);
    `CHK("irq", 1'b0, o_irq)
    pulse(6'h01);
    apb(0, 12'h010, 0);
    `CHK("masked irq", 1'b0, o_irq)
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    $display("status done");
  endtask
  task t_divider;
    int c, s;
    for (int k = 0; k < 16; k++) begin
      // k[3] is the pll bit, k[2:0] the select
      s = (k == 8 || k == 9) ? 2 : k % 8;
      apb(1, 12'h000, k);
      tick(c); tick(c); tick(c);
      `CHK("period", 4 + 2 * s, c)
      `CHK("eff_sel", s[2:0], o_eff_sel)
    end
    $display("divider done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1;
    i_src_en <= 1;
    `CHK("ready", 6'h00, o_pair_ready)
    t_status;
    t_divider;
    give_verdict;
  end
endmodule // tb
